// [inc/cvc_pkg.sv]
// Constants and types shared by the core voltage code output block
package cvc_pkg;

  // ****************************************
  // Code widths and fixed strap values
  // ****************************************
  localparam int unsigned CODE_W = 6;
  localparam int unsigned STRAP_W = 2;

  // Highest-voltage working code, 1.6000 V
  localparam logic [CODE_W-1:0] CODE_MAX_VOLT = 6'h01;
  // Lowest-voltage working code, 0.8500 V
  localparam logic [CODE_W-1:0] CODE_MIN_VOLT = 6'h3d;
  // Both ends of the code space switch the regulator off
  localparam logic [CODE_W-1:0] CODE_OFF_ZERO = 6'h00;
  localparam logic [CODE_W-1:0] CODE_OFF_ONES = 6'h3f;
  // Code held while in reset; a working code, never an off code
  localparam logic [CODE_W-1:0] CODE_RESET = 6'h3d;

  // Step of the voltage ladder, in microvolts per code
  localparam int unsigned STEP_UV = 12500;

  // Loadline slope code for this part
  localparam logic [STRAP_W-1:0] LOADLINE_CODE = 2'h1;
  // Segment key; value is arbitrary
  localparam logic [STRAP_W-1:0] SEGMENT_KEY = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS = 4000;
  // Least dwell on each code before the next single step
  localparam int unsigned STEP_DWELL_NS = 5000;
  localparam int unsigned STEP_DWELL_CYC =
    (STEP_DWELL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned DWELL_W = $clog2(STEP_DWELL_CYC + 1);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic {
    CVC_ST_LOAD,
    CVC_ST_RUN
  } cvc_state_type;

  // Power management requests that may start code transitions
  typedef struct packed {
    logic              thermal_event;
    logic              forced_power_reduction_in;
    logic              ext_halt;
    logic [CODE_W-1:0] perf_code;
    logic [CODE_W-1:0] low_power_code;
  } cvc_pm_req_type;

  // Fixed straps driven toward the regulator
  typedef struct packed {
    logic [STRAP_W-1:0] loadline_select_code;
    logic [STRAP_W-1:0] segment_key_code;
  } cvc_strap_type;

endpackage

// [design/cvc_core_voltage_code.sv]
// Voltage request code generator with single-step transitions and fixed straps

// How it works
// - Drive six-bit code, high means one
// - Higher code means lower voltage, zero off
// - Reach distant targets by single code steps
// - Never step above default voltage
// - Default code comes from per-part fuses
// - Thermal, forced, halt, performance start transitions
// - Drive fixed loadline code 01
// - Drive fixed segment key code
module cvc_core_voltage_code (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          reset_n_i,
  // Per-part default code from fuses
  input  wire logic [cvc_pkg::CODE_W-1:0]    default_code_i,
  // Power management requests
  input  wire cvc_pkg::cvc_pm_req_type       pm_req_i,
  // Toward the regulator
  output logic      [cvc_pkg::CODE_W-1:0]    voltage_request_code_o,
  output cvc_pkg::cvc_strap_type             strap_o,
  // Status
  output logic                               at_target_o,
  output logic      [cvc_pkg::CODE_W-1:0]    target_code_o
);

  // ****************************************
  // Functions
  // ****************************************

  // Keep a code inside [ceiling, lowest working code]
  function automatic logic [cvc_pkg::CODE_W-1:0] clamp_code(
    input logic [cvc_pkg::CODE_W-1:0] code,
    input logic [cvc_pkg::CODE_W-1:0] ceiling
  );
    logic [cvc_pkg::CODE_W-1:0] res;
    res = code;
    if (res < ceiling) begin
      res = ceiling;
    end
    if (res > cvc_pkg::CODE_MIN_VOLT) begin
      res = cvc_pkg::CODE_MIN_VOLT;
    end
    return res;
  endfunction

  // One code toward the target, never more
  function automatic logic [cvc_pkg::CODE_W-1:0] step_toward(
    input logic [cvc_pkg::CODE_W-1:0] cur,
    input logic [cvc_pkg::CODE_W-1:0] tgt
  );
    logic [cvc_pkg::CODE_W-1:0] res;
    res = cur;
    if (tgt > cur) begin
      res = cur + 6'h01;
    end else if (tgt < cur) begin
      res = cur - 6'h01;
    end
    return res;
  endfunction

  // ****************************************
  // State
  // ****************************************
  cvc_pkg::cvc_state_type            state_r;
  cvc_pkg::cvc_state_type            state_nxt;
  logic [cvc_pkg::CODE_W-1:0]        default_r;
  logic [cvc_pkg::CODE_W-1:0]        default_nxt;
  logic [cvc_pkg::CODE_W-1:0]        code_r;
  logic [cvc_pkg::CODE_W-1:0]        code_nxt;
  logic [cvc_pkg::CODE_W-1:0]        target_r;
  logic [cvc_pkg::CODE_W-1:0]        target_nxt;
  logic [cvc_pkg::DWELL_W-1:0]       dwell_r;
  logic [cvc_pkg::DWELL_W-1:0]       dwell_nxt;

  // ****************************************
  // Decode
  // ****************************************
  wire logic                         low_power_req;
  wire logic [cvc_pkg::CODE_W-1:0]   raw_target;
  wire logic [cvc_pkg::CODE_W-1:0]   fuse_code;
  wire logic [cvc_pkg::CODE_W-1:0]   safe_target;
  wire logic                         dwell_done;
  wire logic                         step_en;
  wire logic                         in_run;
  wire logic [cvc_pkg::CODE_W-1:0]   step_code;
  wire logic [cvc_pkg::DWELL_W-1:0]  dwell_dec;
  wire logic [cvc_pkg::DWELL_W-1:0]  dwell_load;

  assign low_power_req = pm_req_i.thermal_event | pm_req_i.forced_power_reduction_in
                       | pm_req_i.ext_halt;
  assign raw_target    = low_power_req ? pm_req_i.low_power_code : pm_req_i.perf_code;

  // Fuse default kept in range
  // A blank fuse word (all zeros) would ask for off; the top working code is used instead.
  assign fuse_code     = clamp_code(default_code_i, cvc_pkg::CODE_MAX_VOLT);

  // Ceiling is the default code
  // Off codes never reach the pins from here: clamping maps 00 up and 3e/3f down.
  assign safe_target   = clamp_code(raw_target, default_r);

  // Single-step spacing divider
  assign in_run        = (state_r == cvc_pkg::CVC_ST_RUN);
  assign dwell_done    = (dwell_r == '0);
  assign step_en       = in_run && dwell_done && (code_r != target_r);
  // Count fits DWELL_W by construction, so the cut drops only zeros
  assign dwell_load    = cvc_pkg::DWELL_W'(cvc_pkg::STEP_DWELL_CYC);
  // Parks at zero so a late target change steps at once
  assign dwell_dec     = dwell_done ? dwell_r : dwell_r - 1'b1;

  // Higher code asks for less voltage
  // Next adjacent code toward the target
  assign step_code     = step_toward(code_r, target_r);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_nxt   = state_r;
    default_nxt = default_r;
    code_nxt    = code_r;
    target_nxt  = target_r;
    dwell_nxt   = dwell_r;
    case (state_r)
      cvc_pkg::CVC_ST_LOAD: begin
        // Capture fuse default
        // Boot load happens before the core runs, so a direct jump is allowed here.
        default_nxt = fuse_code;
        code_nxt    = fuse_code;
        target_nxt  = fuse_code;
        dwell_nxt   = dwell_load;
        state_nxt   = cvc_pkg::CVC_ST_RUN;
      end
      cvc_pkg::CVC_ST_RUN: begin
        target_nxt = safe_target;
        dwell_nxt  = dwell_dec;
        if (step_en) begin
          code_nxt  = step_code;
          dwell_nxt = dwell_load;
        end
      end
      default: begin
        state_nxt = cvc_pkg::CVC_ST_LOAD;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  // Every reset lands in the boot load state
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= cvc_pkg::CVC_ST_LOAD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Latched once, so later fuse noise cannot raise the ceiling
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      default_r <= cvc_pkg::CODE_RESET;
    end else begin
      default_r <= default_nxt;
    end
  end

  // Request code changes only here
  // Reset parks on a working code so the regulator never sees off
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      code_r <= cvc_pkg::CODE_RESET;
    end else begin
      code_r <= code_nxt;
    end
  end

  // Follows the clamped request every cycle in run
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      target_r <= cvc_pkg::CODE_RESET;
    end else begin
      target_r <= target_nxt;
    end
  end

  // Zero in reset; boot load reloads a full dwell
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dwell_r <= '0;
    end else begin
      dwell_r <= dwell_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Six request lines, high is one
  assign voltage_request_code_o = code_r;

  assign strap_o.loadline_select_code = cvc_pkg::LOADLINE_CODE;
  assign strap_o.segment_key_code     = cvc_pkg::SEGMENT_KEY;

  // ****************************************
  // Status
  // ****************************************
  // Low through boot load, so a fresh reset never reads as settled
  assign at_target_o   = in_run && (code_r == target_r);
  assign target_code_o = target_r;

endmodule

// [bench/cvc_asserts.sv]
// Checker for the voltage request code block
module cvc_asserts (
  // Clock and reset
  input wire logic                    clk_i,
  input wire logic                    reset_n_i,
  // Watched ports
  input wire logic [5:0]              default_code_i,
  input wire cvc_pkg::cvc_pm_req_type pm_req_i,
  input wire logic [5:0]              voltage_request_code_o,
  input wire cvc_pkg::cvc_strap_type  strap_o,
  input wire logic                    at_target_o,
  input wire logic [5:0]              target_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] c;
  logic [1:0] live_r;
  int unsigned wait_r;
  assign c = voltage_request_code_o;
  // Boot load jumps, so steps count from edge two
  always_ff @(posedge clk_i) live_r <= {live_r[0], reset_n_i};
  // Cycles off target since the code last moved; too long for a delay range
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || at_target_o || $changed(c)) begin
      wait_r <= '0;
    end else begin
      wait_r <= wait_r + 1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_moved;
    &live_r && $changed(c);
  endsequence
  AST_LOADLINE: assert property (strap_o.loadline_select_code == 2'h1)
    else $error("bad loadline");
  AST_SEGMENT: assert property ($stable(strap_o.segment_key_code))
    else $error("key moved");
  AST_CEILING: assert property (&live_r |-> c >= default_code_i)
    else $error("above default");
  AST_STEP: assert property (s_moved |->
    c - $past(c) == 6'h01 || $past(c) - c == 6'h01) else $error("not one step");
  AST_HOLD: assert property (s_moved |=> $stable(c)[*8]) else $error("glitch");
  AST_MATCH: assert property (s_moved |->
    (c > $past(c)) == ($past(target_code_o) > $past(c))) else $error("wrong way");
  AST_SETTLE: assert property (wait_r <= cvc_pkg::STEP_DWELL_CYC + 1)
    else $error("no step");
  AST_LOAD: assert property ($rose(reset_n_i) |=>
    c == (default_code_i == 6'h00 ? 6'h01 : default_code_i)) else $error("bad load");
endmodule
bind cvc_core_voltage_code cvc_asserts u_cvc_asserts (.clk_i, .reset_n_i, .default_code_i,
  .pm_req_i, .voltage_request_code_o, .strap_o, .at_target_o, .target_code_o);

// [bench/cvc_reg_model.sv]
// Behavioural core regulator fed by the request code
module cvc_reg_model (
  // Clock and power
  input  wire logic       clk_i,
  input  wire logic       power_n_i,
  // Request from the processor
  input  wire logic [7:0] request_i,
  // Regulated output
  output logic            on_o,
  output int              uv_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] code;
  assign code = request_i[6:1];
  assign uv_o = on_o ? 1612500 - 12500 * code : 0;
  always @(posedge clk_i) begin
    if (!power_n_i)
      on_o <= 1'b1;
    else if (code == 6'h00 || code > 6'h3d)
      on_o <= 1'b0;
  end
endmodule

// [bench/tb.sv]
// Self-checking bench for the voltage request code block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk_i = 1'b0, reset_n_i = 1'b0, at_target, on;
  logic [5:0]              default_code_i = 6'h00, code, target;
  cvc_pkg::cvc_pm_req_type pm_req_i = '0;
  cvc_pkg::cvc_strap_type  strap;
  int                      uv, err_count = 0, checked = 0;
  // Request, then expected clamped target
  logic [20:0] rows [6] = '{{3'h0, 6'h20, 6'h30, 6'h20}, {3'h4, 6'h20, 6'h30, 6'h30},
    {3'h2, 6'h20, 6'h30, 6'h30}, {3'h1, 6'h20, 6'h30, 6'h30}, {3'h0, 6'h05, 6'h30, 6'h10},
    {3'h0, 6'h3f, 6'h30, 6'h3d}};
  always #2 clk_i = ~clk_i;
  cvc_core_voltage_code u_cvc_core_voltage_code (.clk_i, .reset_n_i, .default_code_i,
    .pm_req_i, .voltage_request_code_o(code), .strap_o(strap), .at_target_o(at_target),
    .target_code_o(target));
  cvc_reg_model u_cvc_reg_model (.clk_i, .power_n_i(reset_n_i),
    .request_i({1'b0, code, clk_i}), .on_o(on), .uv_o(uv));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait, a step takes over a thousand cycles
  task automatic settle(input logic [14:0] pm);
    pm_req_i = pm;
    tick(2);
    for (int n = 0; n < 3000 && at_target !== 1'b1; n++) tick(1);
  endtask
  task automatic conclude();
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #60000;
    err_count++;
    conclude();
  end
  initial begin
    tick(2);
    check(code, 6'h3d);
    check({at_target, strap}, {1'b0, 2'h1, cvc_pkg::SEGMENT_KEY});
    reset_n_i = 1'b1;
    tick(1);
    check({code, uv}, {6'h01, 32'd1600000});
    reset_n_i = 1'b0;
    default_code_i = 6'h10;
    tick(2);
    reset_n_i = 1'b1;
    tick(2);
    foreach (rows[i]) begin
      pm_req_i = rows[i][20:6];
      tick(2);
      check(target, rows[i][5:0]);
    end
    settle({3'h0, 6'h12, 6'h30});
    check({code, uv}, {6'h12, 32'd1387500});
    settle({3'h4, 6'h12, 6'h05});
    check({code, on}, {6'h10, 1'b1});
    conclude();
  end
endmodule
